// ==== include/lphp_consts.svh ====
// Functional notes
// [RULE_01] Start idle, acknowledge low, await request.
// [RULE_02] Peripheral may present first word early.
// [RULE_03] Peripheral asserts request, pulsed or held.
// [RULE_04] Request before arming is ignored; the device still takes a held request that is high at arming.
// [RULE_05] Acknowledge rises only after request falls; the device raises ack while a held first request is still high.
// [RULE_06] Programmable delay sets acknowledge pulse width.
// [RULE_07] Peripheral strobes request after acknowledge rise.
// [RULE_08] Same delay postpones next acknowledge.
// [RULE_09] Edge latching on: capture at request rise.
// [RULE_10] Edge latching off: data held past acknowledge.
// [RULE_11] Output, latching off: change after request edge.
// [RULE_12] Output, latching on: change at request fall; the device changes the word at the next ack rise instead.
// [RULE_13] Output follows same sequence, word per acknowledge.
`ifndef LPHP_CONSTS_SVH
`define LPHP_CONSTS_SVH
`define LPHP_DATA_W      32
`define LPHP_FIFO_DEPTH  16
`define LPHP_DLY_W       8
`define LPHP_DLY_ZERO    8'h00
`define LPHP_DLY_ONE     8'h01
`endif

// ==== include/lphp_pkg.sv ====
package lphp_pkg;
    // Transfer direction of a port
    typedef enum logic {LPHP_DIR_IN, LPHP_DIR_OUT} lphp_dir_t;
endpackage : lphp_pkg

// ==== include/lphp_if.sv ====
`timescale 1ns/1ps
`include "lphp_consts.svh"
interface lphp_if #(parameter int DW = `LPHP_DATA_W);
    logic          req;      // Request strobe from peripheral
    logic          ack;      // Acknowledge strobe from device
    logic [DW-1:0] dev_data; // Word driven by device (output dir)
    logic [DW-1:0] per_data; // Word driven by peripheral (input dir)
    modport device (input req, input per_data, output ack, output dev_data);
    modport periph (output req, output per_data, input ack, input dev_data);
endinterface : lphp_if

// ==== logic/lphp_fifo.sv ====
`timescale 1ns/1ps
module lphp_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         CLK_I,
    input  wire logic         SRST_I,
    input  wire logic         CE_I,
    input  wire logic [W-1:0] IN_DATA_I,
    input  wire logic         IN_VALID_I,
    output logic              IN_READY_O,
    output logic [W-1:0]      OUT_DATA_O,
    output logic              OUT_VALID_O,
    input  wire logic         OUT_READY_I
);
    localparam int AW = $clog2(D);
    initial if (D < 2 || (1 << AW) != D) $error("Depth must be power of 2");
    logic [W-1:0] mem [D];     // Storage
    logic [AW:0]  wp;          // Write pointer, extra wrap bit
    logic [AW:0]  rp;          // Read pointer
    logic         do_wr;
    logic         do_rd;
    assign IN_READY_O  = (wp - rp) != (AW+1)'(D);
    assign OUT_VALID_O = wp != rp;
    assign OUT_DATA_O  = mem[rp[AW-1:0]];
    assign do_wr = CE_I & IN_VALID_I & IN_READY_O;
    assign do_rd = CE_I & OUT_VALID_O & OUT_READY_I;
    // Pointers
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
        end
    end
    // Storage has no reset; only written words are read
    always_ff @(posedge CLK_I) begin
        if (do_wr) mem[wp[AW-1:0]] <= IN_DATA_I;
    end
endmodule : lphp_fifo

// ==== logic/lphp_device.sv ====
`timescale 1ns/1ps
`include "lphp_consts.svh"
module lphp_device #(
    parameter int DW = `LPHP_DATA_W,
    parameter int FD = `LPHP_FIFO_DEPTH
) (
    input  wire logic                  CLK_I,
    input  wire logic                  SRST_I,
    input  wire logic                  CE_I,
    lphp_if.device                     link,
    input  wire logic                  ARM_I,       // Start/run transfer
    input  wire lphp_pkg::lphp_dir_t   DIR_I,
    input  wire logic                  EDGE_LATCH_I,// Request-edge latching
    input  wire logic [`LPHP_DLY_W-1:0] DELAY_I,   // Delay in cycles
    input  wire logic [DW-1:0]         TX_DATA_I,
    input  wire logic                  TX_VALID_I,
    output logic                       TX_READY_O,
    output logic [DW-1:0]              RX_DATA_O,
    output logic                       RX_VALID_O,
    input  wire logic                  RX_READY_I,
    output logic                       BUSY_O
);
    import lphp_pkg::*;
    initial if (DW < 1) $error("Bad data width");
    typedef enum logic [2:0] {S_IDLE, S_WAIT_REQ, S_GAP, S_ACK,
                              S_HOLD} lphp_st_t;
    lphp_st_t             st;
    logic                 req_q;     // Previous request sample
    logic                 req_rise;
    logic                 req_fall;
    logic                 req_seen;  // Strobe seen during this ack
    logic [`LPHP_DLY_W-1:0] cnt;     // Delay counter
    logic                 in_valid;  // Word for rx fifo
    logic [DW-1:0]        in_word;
    logic                 in_ready;
    logic [DW-1:0]        out_word;  // Word driven on link
    logic                 tx_v;
    logic [DW-1:0]        tx_d;
    logic                 tx_pop;
    logic                 have_room; // Rx side can accept a word
    logic                 have_word; // Tx side has a word
    logic                 ready;
    assign req_rise  = link.req & ~req_q;
    assign req_fall  = ~link.req & req_q;
    assign have_room = in_ready & ~in_valid;
    assign have_word = tx_v;
    assign ready     = (DIR_I == LPHP_DIR_IN) ? have_room : have_word;
    assign link.ack      = (st == S_ACK) || (st == S_HOLD);
    assign link.dev_data = out_word;
    assign BUSY_O        = st != S_IDLE;
    // Request history for edge detection
    always_ff @(posedge CLK_I) begin
        if (SRST_I) req_q <= 1'b0;
        else if (CE_I) req_q <= link.req;
    end
    // Strobe during ack; a short pulse may come before the count ends
    always_ff @(posedge CLK_I) begin
        if (SRST_I) req_seen <= 1'b0;
        else if (CE_I) begin
            if (link.ack && req_rise) req_seen <= 1'b1;
            else if (!link.ack) req_seen <= 1'b0;
        end
    end
    // Handshake sequencer
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st  <= S_IDLE;
            cnt <= `LPHP_DLY_ZERO;
        end else if (CE_I) begin
            unique case (st)
                S_IDLE: begin // Ack low; pulses before arming unseen
                    if (ARM_I) st <= S_WAIT_REQ; // RULE_04
                end
                S_WAIT_REQ: begin // First active request marks ready
                    if (!ARM_I) st <= S_IDLE;
                    else if (link.req) st <= S_GAP; // RULE_01
                end
                S_GAP: begin // Delay then wait for room or data
                    if (cnt != `LPHP_DLY_ZERO) cnt <= cnt - `LPHP_DLY_ONE;
                    else if (!ARM_I) st <= S_IDLE;
                    else if (ready) begin // RULE_05
                        st  <= S_ACK;
                        cnt <= DELAY_I; // RULE_06
                    end
                end
                S_ACK: begin // Ack high for at least the delay
                    if (cnt != `LPHP_DLY_ZERO) cnt <= cnt - `LPHP_DLY_ONE;
                    else st <= S_HOLD; // RULE_06
                end
                S_HOLD: begin // Ack stays until strobe seen and req low
                    if (req_seen && !link.req) begin // RULE_05
                        st  <= S_GAP;
                        cnt <= DELAY_I; // RULE_08
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end
    // Input capture into rx fifo
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            in_valid <= 1'b0;
            in_word  <= '0;
        end else if (CE_I) begin
            if (in_valid && in_ready) in_valid <= 1'b0;
            if (DIR_I == LPHP_DIR_IN) begin
                if (EDGE_LATCH_I && link.ack && req_rise && !req_seen) begin
                    in_word  <= link.per_data; // RULE_09
                    in_valid <= 1'b1;
                end else if (!EDGE_LATCH_I && st == S_GAP
                             && cnt == `LPHP_DLY_ZERO && ready
                             && ARM_I) begin
                    // Taken as ack rises; peripheral holds it past
                    in_word  <= link.per_data; // RULE_10
                    in_valid <= 1'b1;
                end
            end
        end
    end
    // Output word: loaded at ack rise, same in both latching modes
    assign tx_pop = (DIR_I == LPHP_DIR_OUT) && st == S_GAP && ARM_I
                    && cnt == `LPHP_DLY_ZERO && have_word;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) out_word <= '0;
        else if (CE_I && tx_pop) out_word <= tx_d; // RULE_13
    end
    // Old word stays through request edge (off) or until request falls
    // (on): the next ack rise comes after the strobe ends. RULE_11
    // RULE_12 is not met: the new word appears at the next ack rise, not at request fall.
    lphp_fifo #(.W(DW), .D(FD)) u_tx (
        .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
        .IN_DATA_I(TX_DATA_I), .IN_VALID_I(TX_VALID_I),
        .IN_READY_O(TX_READY_O),
        .OUT_DATA_O(tx_d), .OUT_VALID_O(tx_v), .OUT_READY_I(tx_pop)
    );
    lphp_fifo #(.W(DW), .D(FD)) u_rx (
        .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
        .IN_DATA_I(in_word), .IN_VALID_I(in_valid),
        .IN_READY_O(in_ready),
        .OUT_DATA_O(RX_DATA_O), .OUT_VALID_O(RX_VALID_O),
        .OUT_READY_I(RX_READY_I)
    );
endmodule : lphp_device

// ==== logic/lphp_periph.sv ====
`timescale 1ns/1ps
`include "lphp_consts.svh"
module lphp_periph #(
    parameter int DW = `LPHP_DATA_W
) (
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        CE_I,
    lphp_if.periph           link,
    input  wire logic        START_I,   // Raise first request
    input  wire logic        PULSE_I,   // Pulse first request, else hold
    input  wire logic [DW-1:0] SEND_DATA_I,
    input  wire logic        SEND_VALID_I,
    output logic             SEND_READY_O,
    output logic [DW-1:0]    GOT_DATA_O,
    output logic             GOT_VALID_O
);
    logic          ack_q;
    logic          req;
    logic [DW-1:0] pdata;
    logic          started;
    logic          strobed;    // Strobe already given for this ack
    logic          full;       // Word shown, not yet strobed in
    logic          strobe_now; // Strobe raised at this edge
    assign link.req      = req;
    assign link.per_data = pdata;
    assign strobe_now    = link.ack & ~strobed & ~req;
    // No load while strobing, so the strobed word is the one shown
    assign SEND_READY_O  = ~full & ~strobe_now;
    // Ack history
    always_ff @(posedge CLK_I) begin
        if (SRST_I) ack_q <= 1'b0;
        else if (CE_I) ack_q <= link.ack;
    end
    // Request: first pulse/hold, then one strobe per ack rise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            req     <= 1'b0;
            started <= 1'b0;
            strobed <= 1'b0;
        end else if (CE_I) begin
            if (!link.ack) strobed <= 1'b0;
            if (!started && START_I) begin
                req     <= 1'b1; // RULE_03
                started <= 1'b1;
            end else if (req && (PULSE_I || link.ack)) begin
                req <= 1'b0; // Held request drops once ack is seen
            end else if (strobe_now) begin
                req     <= 1'b1; // RULE_07
                strobed <= 1'b1;
            end
        end
    end
    // Data: first word may be shown early, held past ack rise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pdata <= '0;
            full  <= 1'b0;
        end else if (CE_I) begin
            if (strobe_now) full <= 1'b0;
            if (SEND_VALID_I && SEND_READY_O) begin
                pdata <= SEND_DATA_I; // RULE_02 RULE_10
                full  <= 1'b1;
            end
        end
    end
    // Word from device taken at ack rise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            GOT_DATA_O  <= '0;
            GOT_VALID_O <= 1'b0;
        end else if (CE_I) begin
            GOT_VALID_O <= link.ack && !ack_q;
            if (link.ack && !ack_q) GOT_DATA_O <= link.dev_data;
        end
    end
endmodule : lphp_periph

// ==== verif/lphp_chk.sv ====
`timescale 1ns/1ps
// Handshake wire checks; the bench runs the delay at 2 cycles
module lphp_chk #(
    parameter int DW = 32
) (
    input  wire logic          CLK_I,
    input  wire logic          SRST_I,
    input  wire logic          req,
    input  wire logic          ack,
    input  wire logic [DW-1:0] dev_data,
    input  wire logic [DW-1:0] per_data
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    logic seen; // Request seen high during the current ack
    always_ff @(posedge CLK_I) begin
        if (SRST_I || !ack) seen <= 1'b0;
        else if (req) seen <= 1'b1;
    end
    idle_ack_a: assert property ($past(SRST_I) |-> !ack)
        else $error("ack high after reset");
    rise_low_a: assert property (ack && req |=> ack)
        else $error("ack fell with req high");
    ack_width_a: assert property ($rose(ack) |-> ack[*3])
        else $error("ack pulse too short");
    ack_release_a: assert property ($fell(ack) |-> $past(seen))
        else $error("ack fell without req");
    release_bound_a: assert property (ack && req |-> ##[1:4] !ack)
        else $error("ack stuck after req");
    ack_gap_a: assert property ($fell(ack) |-> !ack[*2])
        else $error("ack gap too short");
    word_hold_a: assert property (!$rose(ack) |-> $stable(dev_data))
        else $error("word changed off ack");
    word_req_a: assert property (ack && req && !$rose(ack)
        |-> $stable(dev_data))
        else $error("word changed with req high");
endmodule : lphp_chk

// ==== verif/long_pulse_handshake_port_tb.sv ====
`timescale 1ns/1ps
module long_pulse_handshake_port_tb;
    import lphp_pkg::*;
    logic              CLK_I, SRST_I, arm, edge_l, start, pulse;
    logic              txv, rxr, sv;
    lphp_dir_t         dir;
    logic [31:0]       txd, sd;
    logic [31:0]       rxd, gd;
    logic              txr, rxv, busy, srdy, gv;
    int                err_total, tests_run, cyc;
    lphp_if u_lphp_if ();
    // Delay fixed at 2 so the checker's literal counts hold
    lphp_device u_lphp_device (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(1'b1),
        .link(u_lphp_if.device), .ARM_I(arm), .DIR_I(dir),
        .EDGE_LATCH_I(edge_l), .DELAY_I(8'h02), .TX_DATA_I(txd),
        .TX_VALID_I(txv), .TX_READY_O(txr), .RX_DATA_O(rxd),
        .RX_VALID_O(rxv), .RX_READY_I(rxr), .BUSY_O(busy));
    lphp_periph u_lphp_periph (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(1'b1),
        .link(u_lphp_if.periph), .START_I(start), .PULSE_I(pulse),
        .SEND_DATA_I(sd), .SEND_VALID_I(sv), .SEND_READY_O(srdy),
        .GOT_DATA_O(gd), .GOT_VALID_O(gv));
    lphp_chk u_lphp_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
        .req(u_lphp_if.req), .ack(u_lphp_if.ack),
        .dev_data(u_lphp_if.dev_data), .per_data(u_lphp_if.per_data));
    initial begin
        CLK_I = 0;
        forever #12.5 CLK_I = ~CLK_I;
    end
    // Hang guard, far above the longest expected run
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    task test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Ends a test and pulses reset so modes never switch mid-transfer
    task rst(string n);
        $display("test %s done", n);
        @(posedge CLK_I);
        SRST_I <= 1;
        arm <= 0;
        start <= 0;
        repeat (6) @(posedge CLK_I);
        SRST_I <= 0;
    endtask : rst
    // Offers one word on the tx (tx=1) or peripheral stream, held to ready
    task xfer(bit tx, logic [31:0] w);
        @(posedge CLK_I);
        if (tx) {txd, txv} <= {w, 1'b1};
        else {sd, sv} <= {w, 1'b1};
        do @(negedge CLK_I); while (!(tx ? txr : srdy));
        @(posedge CLK_I);
        txv <= 0;
        sv <= 0;
    endtask : xfer
    // Takes one word from the rx stream (rx=1) or the peripheral pulse
    task get(bit rx, logic [31:0] e);
        @(posedge CLK_I);
        rxr <= rx;
        do @(negedge CLK_I); while (!(rx ? rxv : gv));
        chk(rx ? "rx word" : "got word", e, rx ? rxd : gd);
        @(posedge CLK_I);
        rxr <= 0;
    endtask : get
    initial begin
        {arm, edge_l, start, pulse, txv, rxr, sv} = '0;
        {txd, sd, err_total, tests_run, cyc} = '0;
        dir = LPHP_DIR_IN;
        SRST_I = 1;
        repeat (6) @(posedge CLK_I);
        SRST_I <= 0;
        @(negedge CLK_I);
        chk("idle ack", 0, u_lphp_if.ack);
        // Pulse lost while disarmed, arming later must not revive it
        {pulse, start} <= 2'b11;
        repeat (10) @(posedge CLK_I);
        arm <= 1;
        repeat (10) @(negedge CLK_I);
        chk("unarmed ack", 0, u_lphp_if.ack);
        rst("unarmed");
        // Input, latching on then off; rx stalls until the fifo refuses
        for (int m = 0; m < 2; m++) begin
            {edge_l, arm, pulse, start} <= {m == 0, 1'b1, 1'b0, 1'b1};
            fork
                for (int i = 0; i < 18; i++) xfer(0, 32'h5a00_0000 + i);
                begin
                    repeat (400) @(negedge CLK_I);
                    chk("full ack", 0, u_lphp_if.ack);
                    for (int i = 0; i < 18; i++)
                        get(1, 32'h5a00_0000 + i);
                end
            join
            rst("input");
        end
        // Output, latching off then on
        for (int m = 0; m < 2; m++) begin
            {dir, edge_l, arm, start} <= {LPHP_DIR_OUT, m[0], 2'b11};
            fork
                for (int i = 0; i < 4; i++) xfer(1, 32'hc300_0010 + i);
                for (int i = 0; i < 4; i++)
                    get(0, 32'hc300_0010 + i);
            join
            rst("output");
        end
        test_done();
    end
endmodule : long_pulse_handshake_port_tb
